// ---- verilog/iiag_addr_gen.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Post-decrement uses pointer, then decrements pair.
// - Post-increment uses pointer, then increments pair.
// - Pre-increment bumps pair, uses new value.
// - Accumulator-indexed adds signed accumulator to pointer.
// - Accumulator-indexed leaves accumulator and pointer alone.
// - Plain operand addresses pointer, no change.
// - Steps act on whole pair with carry.
// - Pointer steps never touch condition flags.
// - Indirect read of a virtual operand returns zero.
// - Indirect write to a virtual operand does nothing.
// - Operand write to own pair stores unstepped.
// - Extended set leaves first two pointers unchanged.
// - Extended, access clear, low file: third pointer offset.
// - Access clear, high file maps to top bank.
// - Access set uses bank selector plus file.
// - Inherent and literal ops unaffected by extended set.
// - Literal window spans third pointer to plus 95.
// - Pointer pairs hold fourteen-bit linear addresses.
// - Bank selector and file form fourteen bits.
module iiag_addr_gen (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic extended_set_enable,
    input wire logic access_valid,
    input wire iiag_pkg::iiag_op_t op_kind,
    input wire logic [1:0] ptr_sel,
    input wire logic [7:0] file_addr,
    input wire logic access_sel,
    input wire logic [5:0] bank_selector,
    input wire logic [7:0] accumulator,
    input wire logic is_write,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] mem_rd_data,
    input wire logic ptr_wr_en,
    input wire logic [1:0] ptr_wr_sel,
    input wire logic ptr_wr_high,
    input wire logic [7:0] ptr_wr_data,
    output logic [13:0] data_addr,
    output logic mem_rd_en,
    output logic mem_wr_en,
    output logic [7:0] mem_wr_data,
    output logic [7:0] rd_data,
    output logic [13:0] pointer_pair_0,
    output logic [13:0] pointer_pair_1,
    output logic [13:0] third_pointer
);

    iiag_ptr_if ptr_bus [3] ();
    logic [13:0] ptr_val [3];

    // Three pointer pairs, each one owner module.
    for (genvar i = 0; i < 3; i++)
    begin : g_ptr
        iiag_ptr_reg u_ptr (
            .core_clk(core_clk),
            .sys_rst(sys_rst),
            .ptr(ptr_bus[i])
        );
        assign ptr_val[i] = ptr_bus[i].value;
    end

    logic is_indirect;
    logic [13:0] sel_ptr;
    logic [13:0] acc_offset;
    logic [13:0] indirect_addr;
    logic [13:0] direct_addr;
    logic [13:0] lit_addr;
    logic [13:0] bank_addr;
    logic [13:0] top_addr;
    logic use_literal;
    logic [13:0] eff_addr;
    logic target_virtual;
    logic [13:0] virt_rel;
    logic [1:0] virt_ptr;
    logic virt_valid;
    logic self_write;
    logic do_inc;
    logic do_dec;

    // Indirect operand decode and selected pointer.
    assign is_indirect = (op_kind != iiag_pkg::OP_DIRECT);
    assign sel_ptr = (ptr_sel == 2'd1) ? ptr_val[1]
                   : (ptr_sel == 2'd2) ? ptr_val[2] : ptr_val[0];

    // Accumulator sign-extended to fourteen bits.
    assign acc_offset = {{6{accumulator[7]}}, accumulator};

    // Indirect address per operand kind; the sum wraps in fourteen bits.
    assign indirect_addr = (op_kind == iiag_pkg::OP_PRE_INC) ? sel_ptr + iiag_pkg::ONE14
                         : (op_kind == iiag_pkg::OP_ACC_IDX) ? sel_ptr + acc_offset
                         : sel_ptr;

    // Direct addressing forms: literal window, top bank, bank selector.
    assign use_literal = extended_set_enable && !access_sel && (file_addr <= iiag_pkg::LIT_MAX);
    assign lit_addr = ptr_val[iiag_pkg::LIT_PTR] + {6'h00, file_addr};
    assign top_addr = {iiag_pkg::TOP_BANK, file_addr};
    assign bank_addr = {bank_selector, file_addr};
    assign direct_addr = access_sel ? bank_addr
                       : use_literal ? lit_addr
                       : (file_addr >= iiag_pkg::ACCESS_SPLIT) ? top_addr
                       : {6'h00, file_addr};
    // Only direct access consults the extended bit; indirect paths never do.
    assign eff_addr = is_indirect ? indirect_addr : direct_addr;

    // Detect an indirect target that is itself a virtual operand register.
    assign virt_rel = eff_addr - iiag_pkg::VIRT_LO;
    assign target_virtual = is_indirect && (eff_addr >= iiag_pkg::VIRT_LO)
                          && (eff_addr <= iiag_pkg::VIRT_HI)
                          && (virt_rel[2:0] != 3'd5) && (virt_rel[2:0] != 3'd6)
                          && (virt_rel[2:0] != 3'd7);
    assign virt_ptr = 2'(2 - (virt_rel >> 3));
    assign virt_valid = access_valid && is_write && !is_indirect
                      && (direct_addr >= iiag_pkg::VIRT_LO) && (direct_addr <= iiag_pkg::VIRT_HI)
                      && (virt_rel[2:0] < 3'd5);
    assign self_write = virt_valid;

    // Pointer steps; only the pointer moves, no flag is driven here.
    assign do_inc = access_valid && ((op_kind == iiag_pkg::OP_POST_INC)
                  || (op_kind == iiag_pkg::OP_PRE_INC));
    assign do_dec = access_valid && (op_kind == iiag_pkg::OP_POST_DEC);

    // Per-pointer control: explicit byte writes, operand writes, steps.
    for (genvar i = 0; i < 3; i++)
    begin : g_ctl
        logic byte_wr;
        logic op_wr;
        logic [13:0] byte_val;
        assign byte_wr = ptr_wr_en && (ptr_wr_sel == 2'(i));
        assign op_wr = self_write && (virt_ptr == 2'(i));
        assign byte_val = ptr_wr_high ? {ptr_wr_data[5:0], ptr_val[i][7:0]}
                                      : {ptr_val[i][13:8], ptr_wr_data};
        assign ptr_bus[i].load = byte_wr || op_wr;
        assign ptr_bus[i].load_val = op_wr ? {6'h00, wr_data} : byte_val;
        // A load wins; accumulator-indexed and plain never step.
        assign ptr_bus[i].step_inc = !ptr_bus[i].load && do_inc && (ptr_sel == 2'(i));
        assign ptr_bus[i].step_dec = !ptr_bus[i].load && do_dec && (ptr_sel == 2'(i));
    end

    // Memory strobes; virtual targets neither read nor write.
    assign mem_rd_en = access_valid && !is_write && !target_virtual;
    assign mem_wr_en = access_valid && is_write && !target_virtual && !self_write;
    assign mem_wr_data = wr_data;
    assign data_addr = eff_addr;

    logic [7:0] rd_q;
    logic [7:0] rd_d;

    // Read result is forced to zero for a virtual target.
    assign rd_d = target_virtual ? iiag_pkg::DATA_ZERO : mem_rd_data;

    // Registered read data; it holds between accesses.
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            rd_q <= iiag_pkg::DATA_ZERO;
        else
            rd_q <= access_valid ? rd_d : rd_q;
    end

    // Pointer views come straight from the pointer flip-flops, so updates show next cycle.
    assign rd_data = rd_q;
    assign pointer_pair_0 = ptr_val[0];
    assign pointer_pair_1 = ptr_val[1];
    assign third_pointer = ptr_val[2];

endmodule : iiag_addr_gen

// ---- verilog/iiag_pkg.sv ----
package iiag_pkg;

    // Widths of the data path.
    localparam int ADDR_W = 14;
    localparam int BYTE_W = 8;
    localparam int NUM_PTR = 3;

    // Pointer pair value after reset.
    localparam logic [13:0] PTR_RST = 14'h0000;

    // Access Bank split and remap base.
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [7:0] LIT_MAX = 8'h5F;
    localparam logic [5:0] TOP_BANK = 6'h3F;

    // Virtual operand registers: three groups of five, eight apart; pointer 1 plain at 3FE7h.
    localparam logic [13:0] VIRT_LO = 14'h3FDF;
    localparam logic [13:0] VIRT_HI = 14'h3FF3;
    localparam logic [13:0] VIRT_SPAN = 14'h0008;

    // Index of the pointer that gains the literal-offset window.
    localparam logic [1:0] LIT_PTR = 2'h2;
    localparam logic [7:0] DATA_ZERO = 8'h00;
    localparam logic [13:0] ONE14 = 14'h0001;

    // Operand kinds presented by the execution core.
    typedef enum logic [2:0] {
        OP_DIRECT = 3'b000,
        OP_PLAIN = 3'b001,
        OP_POST_INC = 3'b010,
        OP_POST_DEC = 3'b011,
        OP_PRE_INC = 3'b100,
        OP_ACC_IDX = 3'b101
    } iiag_op_t;

endpackage : iiag_pkg

// ---- verilog/iiag_ptr_if.sv ----
`timescale 1ns/1ps
interface iiag_ptr_if;
    logic [13:0] value;
    logic load;
    logic [13:0] load_val;
    logic step_inc;
    logic step_dec;

    modport owner (output value, input load, input load_val, input step_inc, input step_dec);
    modport user (input value, output load, output load_val, output step_inc, output step_dec);
endinterface : iiag_ptr_if

// ---- verilog/iiag_ptr_reg.sv ----
`timescale 1ns/1ps
module iiag_ptr_reg (
    input wire logic core_clk,
    input wire logic sys_rst,
    iiag_ptr_if.owner ptr
);

    logic [13:0] value_q;
    logic [13:0] value_d;
    logic [13:0] stepped;

    // Whole-pair step so low-byte wrap carries or borrows into the high byte.
    assign stepped = ptr.step_inc ? value_q + iiag_pkg::ONE14 : value_q - iiag_pkg::ONE14;
    // A write through an operand loads the value with no step applied.
    assign value_d = ptr.load ? ptr.load_val
                   : (ptr.step_inc || ptr.step_dec) ? stepped : value_q;
    assign ptr.value = value_q;

    // Pointer pair storage, fourteen bits only.
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            value_q <= iiag_pkg::PTR_RST;
        else
            value_q <= value_d;
    end

endmodule : iiag_ptr_reg

// ---- verif/iiag_mem_model.sv ----
`timescale 1ns/1ps
// Data memory answering reads in the same cycle with an address-derived byte.
module iiag_mem_model (
    input logic [13:0] data_addr,
    input logic mem_rd_en,
    output logic [7:0] mem_rd_data
);
    wire [7:0] pat = data_addr[7:0] ^ {2'h0, data_addr[13:8]};
    // An unselected read shows the inverted pattern so a stale byte never passes.
    assign mem_rd_data = mem_rd_en ? pat : ~pat;
endmodule : iiag_mem_model

// ---- verif/iiag_addr_gen_props.sv ----
`timescale 1ns/1ps
// Checks address forming and pointer stepping at the block's ports.
module iiag_addr_gen_props (
    input logic core_clk,
    input logic sys_rst,
    input logic extended_set_enable,
    input logic access_valid,
    input iiag_pkg::iiag_op_t op_kind,
    input logic [1:0] ptr_sel,
    input logic [7:0] file_addr,
    input logic access_sel,
    input logic [5:0] bank_selector,
    input logic [7:0] accumulator,
    input logic ptr_wr_en,
    input logic [13:0] data_addr,
    input logic mem_rd_en,
    input logic mem_wr_en,
    input logic [13:0] pointer_pair_0,
    input logic [13:0] third_pointer
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // Pointer 0 accesses away from the virtual page, and direct accesses.
    wire p0 = access_valid && ptr_sel == 2'h0 && !ptr_wr_en && pointer_pair_0[13:8] != 6'h3f;
    wire dir = access_valid && op_kind == iiag_pkg::OP_DIRECT;
    wire vt = access_valid && ptr_sel == 2'h0 && !ptr_wr_en && pointer_pair_0 == 14'h3fe7;
    // Pointer 0 one cycle on, stepped by d or left alone.
    sequence stepped(logic [13:0] d);
        ##1 pointer_pair_0 == $past(pointer_pair_0) + d;
    endsequence
    sequence held;
        ##1 $stable(pointer_pair_0);
    endsequence
    post_inc_a: assert property (p0 && op_kind == iiag_pkg::OP_POST_INC
        |-> data_addr == pointer_pair_0 ##0 stepped(14'h0001)) else $error("post increment");
    post_dec_a: assert property (p0 && op_kind == iiag_pkg::OP_POST_DEC
        |-> data_addr == pointer_pair_0 ##0 stepped(14'h3fff)) else $error("post decrement");
    pre_inc_a: assert property (p0 && op_kind == iiag_pkg::OP_PRE_INC
        |-> data_addr == pointer_pair_0 + 14'h0001 ##0 stepped(14'h0001)) else $error("pre inc");
    acc_index_a: assert property (p0 && op_kind == iiag_pkg::OP_ACC_IDX
        |-> data_addr == pointer_pair_0 + {{6{accumulator[7]}}, accumulator} ##0 held)
        else $error("accumulator index");
    plain_use_a: assert property (p0 && op_kind == iiag_pkg::OP_PLAIN
        |-> data_addr == pointer_pair_0 ##0 held) else $error("plain access");
    lit_offset_a: assert property (dir && !access_sel && extended_set_enable
        && file_addr <= 8'h5f |-> data_addr == third_pointer + {6'h00, file_addr})
        else $error("literal offset");
    top_bank_a: assert property (dir && !access_sel && file_addr >= 8'h60
        |-> data_addr == {6'h3f, file_addr}) else $error("top bank");
    bank_sel_a: assert property (dir && access_sel
        |-> data_addr == {bank_selector, file_addr}) else $error("bank select");
    virt_quiet_a: assert property (vt && op_kind == iiag_pkg::OP_PLAIN
        |-> !mem_rd_en && !mem_wr_en) else $error("virtual target strobed");
endmodule : iiag_addr_gen_props

bind iiag_addr_gen iiag_addr_gen_props i_iiag_addr_gen_props (.*);

// ---- verif/iiag_addr_gen_test.sv ----
`timescale 1ns/1ps
module iiag_addr_gen_test;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic extended_set_enable = 1'b0, access_valid = 1'b0, access_sel = 1'b0, is_write = 1'b0;
    logic ptr_wr_en = 1'b0, ptr_wr_high = 1'b0, mem_rd_en, mem_wr_en, vld_q = 1'b0;
    iiag_pkg::iiag_op_t op_kind = iiag_pkg::OP_DIRECT;
    logic [1:0] ptr_sel = 2'h0, ptr_wr_sel = 2'h0;
    logic [5:0] bank_selector = 6'h00;
    logic [7:0] file_addr = 8'h00, accumulator = 8'h00, wr_data = 8'h00, ptr_wr_data = 8'h00;
    logic [7:0] mem_rd_data, mem_wr_data, rd_data;
    logic [13:0] data_addr, pointer_pair_0, pointer_pair_1, third_pointer, ea, da_q;
    logic [36:0] note;
    logic [36:0] notes[$];
    int fails = 0, total_checks = 0, seed = 32'hf33c;
    iiag_addr_gen i_iiag_addr_gen (.*);
    iiag_mem_model i_iiag_mem_model (.*);
    always #25 core_clk = ~core_clk;
    // Expected memory byte for an address, matching the memory's pattern.
    function automatic logic [7:0] mf(input logic [13:0] a);
        return a[7:0] ^ {2'h0, a[13:8]};
    endfunction : mf
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results
    // Issues one access and notes read byte, pointer 0 and address; valid stays up.
    task automatic acc(input iiag_pkg::iiag_op_t op, input logic [13:0] a, p, input logic [8:0] r);
        op_kind = op;
        access_valid = 1'b1;
        notes.push_back({r, p, a});
        @(negedge core_clk);
    endtask : acc
    // Loads a pointer through its two byte writes, low byte first.
    task automatic wp(input logic [1:0] s, input logic [13:0] v);
        access_valid = 1'b0;
        ptr_wr_en = 1'b1;
        ptr_wr_sel = s;
        ptr_wr_data = v[7:0];
        @(negedge core_clk);
        ptr_wr_high = 1'b1;
        ptr_wr_data = {2'h0, v[13:8]};
        @(negedge core_clk);
        ptr_wr_en = 1'b0;
        ptr_wr_high = 1'b0;
    endtask : wp
    // Captures the address of each taken access for the compare one cycle on.
    always @(posedge core_clk)
    begin
        vld_q <= access_valid;
        da_q <= data_addr;
    end
    // Takes the oldest note when a result lands; a note without read check ignores rd_data.
    always @(negedge core_clk)
    begin
        if (vld_q)
        begin
            note = notes.pop_front();
            if (!note[36])
                note[35:28] = rd_data;
            check({rd_data, pointer_pair_0, da_q}, note[35:0]);
        end
    end
    // Main sequence: pointer stepping, indexing, direct forms, virtual targets.
    initial
    begin
        repeat (4) @(negedge core_clk);
        sys_rst = 1'b0;
        wp(2'h0, 14'h00ff);
        wp(2'h2, 14'h2a50);
        extended_set_enable = 1'b1;
        acc(iiag_pkg::OP_POST_INC, 14'h00ff, 14'h0100, {1'b1, mf(14'h00ff)});
        acc(iiag_pkg::OP_POST_DEC, 14'h0100, 14'h00ff, {1'b1, mf(14'h0100)});
        acc(iiag_pkg::OP_PRE_INC, 14'h0100, 14'h0100, {1'b1, mf(14'h0100)});
        acc(iiag_pkg::OP_PLAIN, 14'h0100, 14'h0100, {1'b1, mf(14'h0100)});
        repeat (8)
        begin
            accumulator = 8'($random(seed));
            ea = 14'h0100 + {{6{accumulator[7]}}, accumulator};
            acc(iiag_pkg::OP_ACC_IDX, ea, 14'h0100, {1'b1, mf(ea)});
        end
        for (int i = 0; i < 16; i++)
        begin
            extended_set_enable = i[0];
            access_sel = i[1];
            bank_selector = 6'($random(seed));
            file_addr = i[3:2] == 2'h0 ? 8'h5f : i[3:2] == 2'h1 ? 8'h60 : 8'($random(seed));
            if (access_sel)
                ea = {bank_selector, file_addr};
            else if (file_addr >= 8'h60)
                ea = {6'h3f, file_addr};
            else if (extended_set_enable)
                ea = 14'h2a50 + {6'h00, file_addr};
            else
                ea = {6'h00, file_addr};
            acc(iiag_pkg::OP_DIRECT, ea, 14'h0100, 9'h000);
        end
        wp(2'h0, 14'h3fe7);
        acc(iiag_pkg::OP_PLAIN, 14'h3fe7, 14'h3fe7, 9'h100);
        is_write = 1'b1;
        acc(iiag_pkg::OP_PLAIN, 14'h3fe7, 14'h3fe7, 9'h000);
        access_sel = 1'b1;
        bank_selector = 6'h3f;
        file_addr = 8'he0;
        wr_data = 8'h5a;
        acc(iiag_pkg::OP_DIRECT, 14'h3fe0, 14'h3fe7, 9'h000);
        access_valid = 1'b0;
        is_write = 1'b0;
        @(negedge core_clk);
        check({22'h0, third_pointer}, {22'h0, 14'h005a});
        check({22'h0, pointer_pair_1}, {22'h0, 14'h0000});
        repeat (2) @(negedge core_clk);
        results;
    end
    // Cuts a hang short well past the expected run length.
    initial
    begin
        #20000;
        fails++;
        results;
    end
endmodule : iiag_addr_gen_test
